//--- lqm_compare.v
// One parameter's low/high threshold comparison
module lqm_compare #(
	parameter W = 16
) (
	// Operands
	input  wire [W-1:0] value,
	input  wire [W-1:0] low_thr,
	input  wire [W-1:0] high_thr,
	// Results
	output wire         low_viol,
	output wire         high_viol
);
	// Thresholds at the extremes can never trip, which disables them
	assign low_viol  = (value < low_thr);
	assign high_viol = (value > high_thr);
endmodule

//--- lqm_defines.vh
// Register map, field positions and reset values of the link quality monitor
`ifndef LQM_DEFINES_VH
`define LQM_DEFINES_VH
`define LQM_IDX_MON          5'h1D
`define LQM_IDX_THR          5'h1E
`define LQM_IDX_IRQ_MASK     5'h1F
`define LQM_IDX_PARAM        5'h1C
`define LQM_MON_RESET        16'h0000
`define LQM_THR_RESET        16'h0000
`define LQM_MASK_RESET       16'h0000
`define LQM_BIT_ENABLE       15
`define LQM_BIT_AUTO_RESET   1
`define LQM_WARN_MSB         9
`define LQM_BIT_WR_CMD       12
`define LQM_SEL_MSB          11
`define LQM_SEL_LSB          9
`define LQM_BIT_LOHI         8
`define LQM_BIT_IRQ_LQ       0
`define LQM_NUM_PARAMS       5
`define LQM_LINK_RESET_LEN   8'h10
`endif

//--- lqm_link_monitor.v
// Link quality monitor with Wishbone register access
//
// Decided for this implementation: register access over Wishbone.
`include "lqm_defines.vh"
module lqm_link_monitor #(
	parameter W = 16
) (
	// Clock and reset
	input  wire         clk,
	input  wire         arst_n,
	// Wishbone slave
	input  wire         wb_cyc_i,
	input  wire         wb_stb_i,
	input  wire         wb_we_i,
	input  wire [6:0]   wb_adr_i,
	input  wire [3:0]   wb_sel_i,
	input  wire [31:0]  wb_dat_i,
	output reg  [31:0]  wb_dat_o,
	output reg          wb_ack_o,
	// Receiver status and adapted parameters
	input  wire         link_up_100,
	input  wire [W-1:0] equalizer_coefficient,
	input  wire [W-1:0] gain_control_level,
	input  wire [W-1:0] baseline_wander_level,
	input  wire [W-1:0] freq_offset_level,
	input  wire [W-1:0] freq_control_level,
	// Outputs
	output reg          irq,
	output reg          link_reset_100
);
	localparam NP = `LQM_NUM_PARAMS;

	// Link status is an external pin: three stages, change taken when last two agree
	reg  [2:0]      link_sync;
	reg             link_ok;
	reg             monitor_enable;
	reg             auto_reset_en;
	reg  [2*NP-1:0] warnings;
	reg  [2:0]      parameter_selector;
	reg             low_high_selector;
	reg  [W-1:0]    threshold_data_value;
	reg  [15:0]     interrupt_control_register;
	reg             irq_armed;
	reg  [7:0]      reset_cnt;
	reg  [W-1:0]    low_thr  [0:NP-1];
	reg  [W-1:0]    high_thr [0:NP-1];
	wire [W-1:0]    param_bus [0:NP-1];
	wire [2*NP-1:0] viol;
	wire            access;
	wire            wr;
	wire            rd_mon;
	wire            active;
	wire [4:0]      idx;
	wire            lo_lane;
	wire            hi_lane;
	reg  [31:0]     next_rdata;
	reg  [2*NP-1:0] next_warnings;

	assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign idx     = wb_adr_i[6:2];
	assign wr      = access & wb_we_i;
	assign rd_mon  = access & ~wb_we_i & (idx == `LQM_IDX_MON);
	assign lo_lane = wb_sel_i[0];
	assign hi_lane = wb_sel_i[1];
	assign active  = monitor_enable & link_ok;

	assign param_bus[0] = equalizer_coefficient;
	assign param_bus[1] = gain_control_level;
	assign param_bus[2] = baseline_wander_level;
	assign param_bus[3] = freq_offset_level;
	assign param_bus[4] = freq_control_level;

	// Bit 2p is low, 2p+1 is high, matching the register layout
	genvar p;
	generate
		for (p = 0; p < NP; p = p + 1)
		begin : g_cmp
			lqm_compare #(.W(W)) u_cmp (
				.value     (param_bus[p]),
				.low_thr   (low_thr[p]),
				.high_thr  (high_thr[p]),
				.low_viol  (viol[2*p]),
				.high_viol (viol[2*p+1])
			);
		end
	endgenerate

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			link_sync <= 3'h0;
			link_ok   <= 1'b0;
		end
		else
		begin
			link_sync <= {link_sync[1:0], link_up_100};
			if (link_sync[2] == link_sync[1])
				link_ok <= link_sync[1];
		end
	end

	// Set beats the clear-on-read so a violation in the read cycle survives
	always @*
	begin
		next_warnings = warnings;
		if (rd_mon)
			next_warnings = {2*NP{1'b0}};
		if (active)
			next_warnings = next_warnings | viol | (warnings & ~{2*NP{rd_mon}});
	end

	always @*
	begin
		next_rdata = 32'h0000_0000;
		case (idx)
			`LQM_IDX_MON:
			begin
				next_rdata[`LQM_BIT_ENABLE]         = monitor_enable;
				next_rdata[`LQM_WARN_MSB:0]         = warnings;
			end
			`LQM_IDX_THR:
			begin
				// Command bit reads zero
				next_rdata[`LQM_SEL_MSB:`LQM_SEL_LSB] = parameter_selector;
				next_rdata[`LQM_BIT_LOHI]             = low_high_selector;
				// Selectors past the last parameter read zero, not unknown
				if (parameter_selector < NP)
					next_rdata[31:16] = low_high_selector ?
						high_thr[parameter_selector] : low_thr[parameter_selector];
			end
			`LQM_IDX_PARAM:
				if (parameter_selector < NP)
					next_rdata[W-1:0] = param_bus[parameter_selector];
			`LQM_IDX_IRQ_MASK:
				next_rdata[15:0] = interrupt_control_register;
			default:
				next_rdata = 32'h0000_0000;
		endcase
	end

	integer i;
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_ack_o                   <= 1'b0;
			wb_dat_o                   <= 32'h0000_0000;
			monitor_enable             <= 1'b0;
			auto_reset_en              <= 1'b0;
			warnings                   <= {2*NP{1'b0}};
			parameter_selector         <= 3'h0;
			low_high_selector          <= 1'b0;
			threshold_data_value       <= {W{1'b0}};
			interrupt_control_register <= `LQM_MASK_RESET;
			irq_armed                  <= 1'b1;
			irq                        <= 1'b0;
			reset_cnt                  <= 8'h00;
			link_reset_100             <= 1'b0;
			for (i = 0; i < NP; i = i + 1)
			begin
				low_thr[i]  <= {W{1'b0}};
				high_thr[i] <= {W{1'b1}};
			end
		end
		else
		begin
			wb_ack_o <= access;
			wb_dat_o <= access & ~wb_we_i ? next_rdata : 32'h0000_0000;
			warnings <= next_warnings;
			// Bits 14:10 stay reserved, so the auto reset control lives in the mask word
			if (wr && idx == `LQM_IDX_MON && hi_lane)
				monitor_enable <= wb_dat_i[`LQM_BIT_ENABLE];
			if (wr && idx == `LQM_IDX_THR)
			begin
				if (hi_lane)
				begin
					parameter_selector <= wb_dat_i[`LQM_SEL_MSB:`LQM_SEL_LSB];
					low_high_selector  <= wb_dat_i[`LQM_BIT_LOHI];
				end
				if (wb_sel_i[2] && wb_sel_i[3])
					threshold_data_value <= wb_dat_i[16+W-1:16];
				// Write uses the selector and data carried in this same access
				if (hi_lane && wb_dat_i[`LQM_BIT_WR_CMD] && wb_dat_i[`LQM_SEL_MSB:`LQM_SEL_LSB] < NP)
				begin
					if (wb_dat_i[`LQM_BIT_LOHI])
						high_thr[wb_dat_i[`LQM_SEL_MSB:`LQM_SEL_LSB]] <= wb_dat_i[16+W-1:16];
					else
						low_thr[wb_dat_i[`LQM_SEL_MSB:`LQM_SEL_LSB]] <= wb_dat_i[16+W-1:16];
				end
			end
			if (wr && idx == `LQM_IDX_IRQ_MASK)
			begin
				if (lo_lane)
				begin
					interrupt_control_register[7:0] <= wb_dat_i[7:0];
					auto_reset_en                   <= wb_dat_i[`LQM_BIT_AUTO_RESET];
				end
				if (hi_lane)
					interrupt_control_register[15:8] <= wb_dat_i[15:8];
			end
			// One interrupt per batch of warnings until a read re-arms
			if (rd_mon)
				irq_armed <= 1'b1;
			else if (irq)
				irq_armed <= 1'b0;
			irq <= (|next_warnings) & interrupt_control_register[`LQM_BIT_IRQ_LQ]
				& (irq_armed | irq) & ~rd_mon;
			// Fixed-length reset pulse on any violation while the counter is idle
			if (reset_cnt != 8'h00)
				reset_cnt <= reset_cnt - 8'h01;
			else if (auto_reset_en && active && (|viol))
				reset_cnt <= `LQM_LINK_RESET_LEN;
			link_reset_100 <= (reset_cnt != 8'h00);
		end
	end
endmodule

//--- lqm_properties.sv
// Bus and interrupt checker for the link quality monitor
module lqm_checker (
	// Clock and reset
	input logic        clk,
	input logic        arst_n,
	// Bus
	input logic        wb_cyc_i,
	input logic        wb_stb_i,
	input logic        wb_we_i,
	input logic [6:0]  wb_adr_i,
	input logic [31:0] wb_dat_o,
	input logic        wb_ack_o,
	// Status
	input logic        irq,
	input logic        link_reset_100
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	wire rd_mon = wb_ack_o && !wb_we_i && wb_adr_i[6:2] == 5'h1D;
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_follows_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside read ack");
	reserved_zero_a: assert property (rd_mon |-> wb_dat_o[14:10] == 5'h00)
		else $error("reserved bits read non-zero");
	cmd_reads_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[6:2] == 5'h1E |-> !wb_dat_o[12])
		else $error("write command bit read as one");
	irq_holds_a: assert property (irq && !(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[6:2] == (wb_we_i ? 5'h1F : 5'h1D)) |=> irq)
		else $error("interrupt dropped without a read");
	reset_pulse_a: assert property ($rose(link_reset_100) |-> link_reset_100[*8] ##1 link_reset_100[*8] ##1 !link_reset_100)
		else $error("link reset pulse not 16 cycles");
endmodule
bind lqm_link_monitor lqm_checker u_lqm_checker (.*);

//--- tb_top.sv
// Register level testbench for the link quality monitor
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0;
	logic        arst_n = 0;
	logic        cyc = 0;
	logic        stb = 0;
	logic        we = 0;
	logic [6:0]  adr = 0;
	logic [31:0] dat = 0;
	logic [31:0] rdat;
	logic        ack;
	logic        irq;
	logic        lrst;
	logic        link = 0;
	logic [15:0] lvl [5] = '{5{16'h0800}};
	int          bad_count = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          n;
	logic [31:0] w;
	lqm_link_monitor DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.link_up_100(link), .equalizer_coefficient(lvl[0]), .gain_control_level(lvl[1]),
		.baseline_wander_level(lvl[2]), .freq_offset_level(lvl[3]), .freq_control_level(lvl[4]),
		.irq(irq), .link_reset_100(lrst));
	always #4 clk = ~clk;
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			tally_and_finish;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
			begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Ack is read before the edge's own updates land, so it is the sampled value
	task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= wr;
		adr <= {a, 2'b00};
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(0, a, 0, q);
		chk(q, e);
	endtask
	task automatic kick(input int p, input logic [15:0] v);
		lvl[p] <= v;
		@(posedge clk);
		lvl[p] <= 16'h0800;
		repeat (3) @(posedge clk);
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		arst_n <= 1;
		rd(5'h1D, 0);
		rd(5'h05, 0);
		wr(5'h1D, 32'hFC00);
		rd(5'h1D, 32'h8000);
		wr(5'h1F, 1);
		$display("registers done");
		for (int p = 0; p < 5; p++)
			for (int h = 0; h < 2; h++)
			begin
				w = {(h ? 16'h1000 : 16'h0100), 4'h1, 3'(p), 1'(h), 8'h00};
				wr(5'h1E, w);
				rd(5'h1E, w & ~32'h1000);
			end
		rd(5'h1C, 32'h0800);
		$display("thresholds done");
		link <= 1;
		repeat (6) @(posedge clk);
		for (int p = 0; p < 5; p++)
			for (int h = 0; h < 2; h++)
			begin
				kick(p, h ? 16'h2000 : 16'h0010);
				chk(irq, 1);
				rd(5'h1D, 32'h8000 | 32'(1 << (2 * p + h)));
				repeat (2) @(posedge clk);
				chk(irq, 0);
				rd(5'h1D, 32'h8000);
			end
		$display("warnings done");
		link <= 0;
		repeat (6) @(posedge clk);
		kick(0, 16'h2000);
		rd(5'h1D, 32'h8000);
		link <= 1;
		wr(5'h1D, 0);
		repeat (6) @(posedge clk);
		kick(0, 16'h2000);
		rd(5'h1D, 0);
		wr(5'h1F, 0);
		wr(5'h1D, 32'h8000);
		kick(0, 16'h2000);
		chk(irq, 0);
		rd(5'h1D, 32'h8002);
		wr(5'h1E, 32'hFFFF_1300);
		kick(1, 16'hFFFF);
		rd(5'h1D, 32'h8000);
		$display("gating done");
		wr(5'h1F, 32'h2);
		rd(5'h1F, 32'h2);
		rd(5'h1D, 32'h8000);
		lvl[0] <= 16'h2000;
		@(posedge clk);
		lvl[0] <= 16'h0800;
		n = 0;
		repeat (24)
		begin
			@(posedge clk);
			n += lrst;
		end
		chk(n, 16);
		$display("auto reset done");
		tally_and_finish;
	end
endmodule
